/* wpnv_pkg.sv */
package wpnv_pkg;
  // ************************************************************
  // memory map and timing
  // ************************************************************
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned MEM_BYTES = 2048;
  localparam int unsigned PAGE_BYTES = 16;
  localparam logic [10:0] GP_TOP_ADDR = 11'h7FB;
  localparam logic [10:0] RSVD_LOW_ADDR = 11'h7FC;
  localparam logic [10:0] RSVD_HIGH_ADDR = 11'h7FD;
  localparam logic [10:0] VOL_CTRL_ADDR = 11'h7FE;
  localparam logic [10:0] WIPER_ADDR = 11'h7FF;
  localparam int unsigned VOL_BIT_POS = 7;
  localparam logic [6:0] WIPER_RESET = 7'h40;
  localparam logic [7:0] NV_ERASED = 8'hFF;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned NV_WRITE_CYCLE_TIME_US = 12000;
  localparam int unsigned NV_WRITE_CYCLES = NV_WRITE_CYCLE_TIME_US * CLK_MHZ;
  localparam int unsigned LOAD_DELAY_CYCLES = 4;
  // ************************************************************
  // apb register offsets of the host controller
  // ************************************************************
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int unsigned CMD_WRITE_POS = 0;
  localparam int unsigned CMD_READ_POS = 1;
  localparam int unsigned CMD_LEN_POS = 4;
  localparam int unsigned ST_BUSY_POS = 0;
  localparam int unsigned ST_DONE_POS = 1;
  localparam int unsigned ST_NACK_POS = 2;
endpackage : wpnv_pkg

/* wpnv_if.sv */
`timescale 1ns/1ns
// ************************************************************
// transaction link between host controller and device
// ************************************************************
interface wpnv_if;
  logic start;
  logic wr;
  logic [10:0] addr;
  logic [7:0] wdata;
  logic wvalid;
  logic stop;
  logic rreq;
  logic [7:0] rdata;
  logic rvalid;
  logic busy;
  modport dev (input start, input wr, input addr, input wdata, input wvalid, input stop, input rreq,
    output rdata, output rvalid, output busy);
  modport host (output start, output wr, output addr, output wdata, output wvalid, output stop, output rreq,
    input rdata, input rvalid, input busy);
endinterface : wpnv_if

/* wpnv_device.sv */
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
// How it works
// RULE_01: wiper register is exactly seven bits
// RULE_02: value 00 low end, 7F high end
// RULE_03: wiper resets to mid-scale 40 hex
// RULE_04: stored initial value then loaded into wiper
// RULE_05: 2048 stored bytes in 16-byte pages
// RULE_06: one page written per programming cycle
// RULE_07: decode addresses 000 through 7FF hex
// RULE_08: bytes up to 7FB are general storage
// RULE_09: host avoids reserved bytes 7FC, 7FD; only writes starting there are refused
// RULE_10: top address reaches wiper and initial value
// RULE_11: control bit seven volatile, reset zero
// RULE_12: top read picks wiper or stored value
// RULE_13: top write updates wiper, maybe stored value
// RULE_14: host writes control low bits zero
// RULE_15: control and top in one or two writes
// RULE_16: programming timed internally from stop
// RULE_17: programming starts only at write stop
// RULE_18: address eleven bits from frame address
// RULE_19: top write loads wiper on data byte
// RULE_20: host keeps multi-byte writes in page
// RULE_21: wiper reads return zero in bit seven
module wpnv_device #(
  parameter int unsigned NV_CYCLES = wpnv_pkg::NV_WRITE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  wpnv_if.dev link,
  output logic [6:0] digital_potentiometer,
  output logic volatile_only_bit
);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {
    WPNV_BOOT = 2'b00,
    WPNV_IDLE = 2'b01,
    WPNV_XFER = 2'b10,
    WPNV_PROG = 2'b11
  } wpnv_state_e;

  // address of one slot within the page of a base address; page writes wrap inside it
  function automatic logic [10:0] wpnv_slot_addr(
    input logic [10:0] base,
    input logic [3:0] slot_idx
  );
    wpnv_slot_addr = {base[10:4], slot_idx};
  endfunction : wpnv_slot_addr

  logic [7:0] mem [0:wpnv_pkg::MEM_BYTES-1]; // RULE_05
  logic [7:0] page_buf [0:wpnv_pkg::PAGE_BYTES-1];
  logic [wpnv_pkg::PAGE_BYTES-1:0] page_mask_r;
  logic [10:0] page_base_r;
  logic [10:0] ptr_r;
  wpnv_state_e state_r;
  logic [31:0] cnt_r;
  logic [6:0] wiper_r;
  logic vol_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic nv_pending_r;
  logic [wpnv_pkg::PAGE_BYTES-1:0] commit_en;

  // ************************************************************
  // address decode
  // ************************************************************
  // decode of the live pointer; a cycle carrying stop or start moves no data
  wire is_top = (ptr_r == wpnv_pkg::WIPER_ADDR); // RULE_10
  wire is_ctrl = (ptr_r == wpnv_pkg::VOL_CTRL_ADDR);
  wire is_gp = (ptr_r <= wpnv_pkg::GP_TOP_ADDR); // RULE_08
  wire in_xfer = (state_r == WPNV_XFER);
  wire framing = link.stop || link.start;
  wire wr_hit = in_xfer && !framing && link.wvalid;
  wire rd_hit = in_xfer && !framing && !link.wvalid && link.rreq;
  wire boot_load = (state_r == WPNV_BOOT) && (cnt_r == wpnv_pkg::LOAD_DELAY_CYCLES);
  wire nv_byte = is_gp || (is_top && !vol_r); // RULE_13
  wire [3:0] slot = ptr_r[3:0];
  wire [3:0] slot_next = 4'(slot + 4'h1);
  wire [7:0] top_rd = vol_r ? {1'b0, wiper_r} : {1'b0, mem[wpnv_pkg::WIPER_ADDR][6:0]}; // RULE_12 RULE_21
  wire [7:0] rd_sel = is_top ? top_rd : is_ctrl ? {vol_r, 7'h00} : mem[ptr_r];

  // ************************************************************
  // outputs
  // ************************************************************
  // wiper, control bit and read byte straight from their registers
  assign digital_potentiometer = wiper_r; // RULE_01 RULE_02
  assign volatile_only_bit = vol_r;
  assign link.rdata = rdata_r;
  assign link.rvalid = rvalid_r;
  assign link.busy = (state_r == WPNV_PROG) || (state_r == WPNV_BOOT);

  // ************************************************************
  // sequencing
  // ************************************************************
  // state machine: boot load, transfer, self-timed programming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= WPNV_BOOT;
      cnt_r <= 32'h0000_0000;
      ptr_r <= 11'h000;
      page_base_r <= 11'h000;
      page_mask_r <= '0;
      nv_pending_r <= 1'b0;
    end else begin
      case (state_r)
        WPNV_BOOT: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (boot_load) begin
            state_r <= WPNV_IDLE; // RULE_04
          end
        end
        WPNV_IDLE: begin
          if (link.start) begin
            ptr_r <= link.addr; // RULE_07 RULE_18
            page_base_r <= wpnv_slot_addr(link.addr, 4'h0);
            page_mask_r <= '0;
            nv_pending_r <= 1'b0;
            state_r <= WPNV_XFER;
          end
        end
        WPNV_XFER: begin
          if (link.stop) begin
            cnt_r <= 32'h0000_0000;
            state_r <= nv_pending_r ? WPNV_PROG : WPNV_IDLE; // RULE_16 RULE_17
          end else if (link.start) begin
            ptr_r <= link.addr;
            page_base_r <= wpnv_slot_addr(link.addr, 4'h0);
          end else if (wr_hit) begin
            if (nv_byte) begin
              page_mask_r[slot] <= 1'b1; // RULE_06
              nv_pending_r <= 1'b1;
            end
            ptr_r <= wpnv_slot_addr(ptr_r, slot_next);
          end else if (rd_hit) begin
            ptr_r <= 11'(ptr_r + 11'h001);
          end
        end
        WPNV_PROG: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (cnt_r >= NV_CYCLES - 1) begin
            state_r <= WPNV_IDLE; // RULE_16
          end
        end
        default: state_r <= WPNV_IDLE;
      endcase
    end
  end

  // live wiper: mid-scale at reset, stored copy after boot, host bytes at the top location
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wiper_r <= wpnv_pkg::WIPER_RESET; // RULE_03
    end else if (boot_load) begin
      wiper_r <= mem[wpnv_pkg::WIPER_ADDR][6:0]; // RULE_04
    end else if (wr_hit && is_top) begin
      wiper_r <= link.wdata[6:0]; // RULE_19
    end
  end

  // volatile-only select, cleared at every reset and never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vol_r <= 1'b0; // RULE_11
    end else if (wr_hit && is_ctrl) begin
      vol_r <= link.wdata[wpnv_pkg::VOL_BIT_POS]; // RULE_15
    end
  end

  // read return: one byte a request, flagged for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rd_hit;
      if (rd_hit) begin
        rdata_r <= rd_sel; // RULE_12
      end
    end
  end

  // ************************************************************
  // page buffer and stored array
  // ************************************************************
  // page buffer capture of incoming data; the top byte keeps seven bits
  always_ff @(posedge pclk) begin
    if (wr_hit && nv_byte) begin
      page_buf[slot] <= is_top ? {1'b0, link.wdata[6:0]} : link.wdata;
    end
  end

  // one commit enable a slot, those of written slots raised in the first programming cycle
  for (genvar g = 0; g < wpnv_pkg::PAGE_BYTES; g++) begin : g_commit
    assign commit_en[g] = (state_r == WPNV_PROG) && (cnt_r == 32'h0000_0000) && page_mask_r[g];
  end

  // written slots of the page committed at once; a single writer process, since the image below preloads the cells
  always @(posedge pclk) begin
    for (int k = 0; k < wpnv_pkg::PAGE_BYTES; k++) begin
      if (commit_en[k]) begin
        mem[wpnv_slot_addr(page_base_r, 4'(k))] <= page_buf[k]; // RULE_06
      end
    end
  end

  // cells start erased, with mid-scale as the stored initial wiper value
  initial begin
    for (int i = 0; i < wpnv_pkg::MEM_BYTES; i++) begin
      mem[i] = (i == wpnv_pkg::MEM_BYTES - 1) ? {1'b0, wpnv_pkg::WIPER_RESET} : wpnv_pkg::NV_ERASED;
    end
  end
endmodule : wpnv_device

/* wpnv_host.sv */
`timescale 1ns/1ns
module wpnv_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  wpnv_if.host link
);
  // ************************************************************
  // host controller: apb registers drive link transactions
  // ************************************************************
  typedef enum logic [2:0] {
    WPNV_H_IDLE = 3'b000,
    WPNV_H_START = 3'b001,
    WPNV_H_DATA = 3'b010,
    WPNV_H_STOP = 3'b011,
    WPNV_H_WAIT = 3'b100
  } wpnv_hstate_e;

  wpnv_hstate_e state_r;
  logic [10:0] addr_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic [2:0] len_r;
  logic [2:0] idx_r;
  logic is_rd_r;
  logic done_r;
  logic nack_r;

  wire acc = psel && penable;
  wire wr_acc = acc && pwrite;
  wire cmd_hit = wr_acc && (paddr == wpnv_pkg::REG_CMD) && (state_r == WPNV_H_IDLE);
  wire go_wr = cmd_hit && pwdata[wpnv_pkg::CMD_WRITE_POS];
  wire go_rd = cmd_hit && pwdata[wpnv_pkg::CMD_READ_POS];
  wire map_ok = (paddr == wpnv_pkg::REG_CMD) || (paddr == wpnv_pkg::REG_ADDR) || (paddr == wpnv_pkg::REG_WDATA)
    || (paddr == wpnv_pkg::REG_RDATA) || (paddr == wpnv_pkg::REG_STATUS);
  wire [31:0] status_w = {29'h0, nack_r, done_r, state_r != WPNV_H_IDLE};
  // write commands starting at address 7FC or 7FD are refused
  wire rsvd = (addr_r == wpnv_pkg::RSVD_LOW_ADDR) || (addr_r == wpnv_pkg::RSVD_HIGH_ADDR); // RULE_09

  assign pready = 1'b1;
  assign pslverr = acc && !map_ok;
  assign link.start = (state_r == WPNV_H_START);
  assign link.wr = !is_rd_r;
  assign link.addr = addr_r;
  assign link.stop = (state_r == WPNV_H_STOP);
  assign link.wvalid = (state_r == WPNV_H_DATA) && !is_rd_r;
  assign link.rreq = (state_r == WPNV_H_DATA) && is_rd_r;
  // control byte low bits forced zero; bytes of pwdata go lowest first
  assign link.wdata = (11'(addr_r + 11'(idx_r)) == wpnv_pkg::VOL_CTRL_ADDR) ?
    {wdata_r[8 * idx_r + 7], 7'h00} : wdata_r[8 * idx_r +: 8]; // RULE_14 RULE_15

  // read mux
  always_comb begin
    case (paddr)
      wpnv_pkg::REG_ADDR: prdata = {21'h0, addr_r};
      wpnv_pkg::REG_WDATA: prdata = wdata_r;
      wpnv_pkg::REG_RDATA: prdata = rdata_r;
      wpnv_pkg::REG_STATUS: prdata = status_w;
      default: prdata = 32'h0000_0000;
    endcase
  end

  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= WPNV_H_IDLE;
      addr_r <= 11'h000;
      wdata_r <= 32'h0000_0000;
      rdata_r <= 32'h0000_0000;
      len_r <= 3'h0;
      idx_r <= 3'h0;
      is_rd_r <= 1'b0;
      done_r <= 1'b0;
      nack_r <= 1'b0;
    end else begin
      if (wr_acc && paddr == wpnv_pkg::REG_ADDR && state_r == WPNV_H_IDLE) addr_r <= pwdata[10:0];
      if (wr_acc && paddr == wpnv_pkg::REG_WDATA && state_r == WPNV_H_IDLE) wdata_r <= pwdata;
      if (wr_acc && paddr == wpnv_pkg::REG_STATUS) begin
        done_r <= 1'b0;
        nack_r <= 1'b0;
      end
      case (state_r)
        WPNV_H_IDLE: begin
          if (go_wr || go_rd) begin
            is_rd_r <= go_rd;
            len_r <= (pwdata[6:4] > 3'h3) ? 3'h3 : pwdata[6:4];
            idx_r <= 3'h0;
            if (go_wr && rsvd) begin
              nack_r <= 1'b1; // RULE_09
              done_r <= 1'b1;
            end else if (!link.busy) begin
              state_r <= WPNV_H_START;
              if (go_rd) rdata_r <= 32'h0000_0000;
            end else begin
              nack_r <= 1'b1; // RULE_16
              done_r <= 1'b1;
            end
          end
        end
        WPNV_H_START: state_r <= WPNV_H_DATA;
        WPNV_H_DATA: begin
          if (is_rd_r) state_r <= WPNV_H_WAIT;
          else begin
            idx_r <= idx_r + 3'h1;
            // stay within one page
            if (idx_r == len_r || addr_r[3:0] + 4'(idx_r) == 4'hF) state_r <= WPNV_H_STOP; // RULE_20
          end
        end
        WPNV_H_WAIT: begin
          if (link.rvalid) begin
            rdata_r[8 * idx_r +: 8] <= link.rdata;
            idx_r <= idx_r + 3'h1;
            state_r <= (idx_r == len_r) ? WPNV_H_STOP : WPNV_H_DATA;
          end
        end
        WPNV_H_STOP: begin
          state_r <= WPNV_H_IDLE;
          done_r <= 1'b1;
        end
        default: state_r <= WPNV_H_IDLE;
      endcase
    end
  end
endmodule : wpnv_host

/* wpnv_link_monitor.sv */
`timescale 1ns/1ns
// ********
// link checker
// ********
module wpnv_link_monitor #(
  parameter int unsigned NV_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic wr,
  input wire logic [10:0] addr,
  input wire logic stop,
  input wire logic rreq,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic busy
);
  localparam int NV_MAX = NV_CYCLES + 8;
  logic [10:0] ptr_r;
  logic [10:0] rd_at_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // track the address each read byte comes from
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_r <= 11'h000;
      rd_at_r <= 11'h000;
    end else if (start) begin
      ptr_r <= addr;
    end else if (rreq) begin
      ptr_r <= ptr_r + 11'h001;
      rd_at_r <= ptr_r;
    end
  end
  rd_answer_a:
  assert property (rreq |=> rvalid) else $error("no rvalid after rreq");
  rd_cause_a:
  assert property (rvalid |-> $past(rreq)) else $error("rvalid without rreq");
  boot_busy_a:
  assert property (!$past(presetn) |-> busy[*4]) else $error("busy short after reset");
  nv_on_stop_a:
  assert property ($rose(busy) |-> $past(stop) || $past(stop, 2)) else $error("busy rose without stop");
  read_no_nv_a:
  assert property (stop && !wr && !busy |=> !busy[*3]) else $error("busy after read");
  nv_hold_a:
  assert property ($rose(busy) |-> busy[*8]) else $error("write cycle too short");
  nv_end_a:
  assert property ($rose(busy) |-> ##[1:NV_MAX] !busy) else $error("write cycle too long");
  top_bit7_a:
  assert property (rvalid && rd_at_r == 11'h7FF |-> rdata[7] == 1'b0) else $error("wiper bit7 set");
endmodule : wpnv_link_monitor

/* tb_wiper_register_and_nv_memory_map.sv */
`timescale 1ns/1ns
module tb_wiper_register_and_nv_memory_map;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, vol, nk, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [6:0] wiper;
  logic [10:0] gp[2] = '{11'h000, 11'h7F8};
  logic [7:0] tv[2] = '{8'hFF, 8'h00};
  int checked = 0;
  int n_mismatch = 0;
  wpnv_if lnk();
  wpnv_device #(.NV_CYCLES(60)) wpnv_device_i (.pclk(pclk), .presetn(presetn), .link(lnk),
    .digital_potentiometer(wiper), .volatile_only_bit(vol));
  wpnv_host wpnv_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
  wpnv_link_monitor #(.NV_CYCLES(60)) wpnv_link_monitor_i (.pclk(pclk), .presetn(presetn), .start(lnk.start),
    .wr(lnk.wr), .addr(lnk.addr), .stop(lnk.stop), .rreq(lnk.rreq), .rdata(lnk.rdata), .rvalid(lnk.rvalid),
    .busy(lnk.busy));
  // ********
  // tasks
  // ********
  always #5 pclk = ~pclk;
  task automatic end_sim;
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic op(input logic w, input logic [10:0] a, input int len, input logic [31:0] d);
    logic [31:0] s;
    apb(1'b1, wpnv_pkg::REG_ADDR, {21'h0, a}, s);
    if (w) apb(1'b1, wpnv_pkg::REG_WDATA, d, s);
    apb(1'b1, wpnv_pkg::REG_CMD, 32'((len - 1) << 4) | (w ? 32'h1 : 32'h2), s);
    s = 32'h0;
    for (int i = 0; i < 200 && s[2:1] === 2'b00; i++) apb(1'b0, wpnv_pkg::REG_STATUS, 32'h0, s);
    nk = s[2];
    apb(1'b0, wpnv_pkg::REG_RDATA, 32'h0, q);
    apb(1'b1, wpnv_pkg::REG_STATUS, 32'h6, s);
  endtask : op
  task automatic idle;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 2000 && lnk.busy !== 1'b0; i++) @(posedge pclk);
  endtask : idle
  // ********
  // tests
  // ********
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    chk(32'(wiper), 32'h40);
    chk(32'(vol), 32'h0);
    presetn <= 1'b1;
    idle();
    chk(32'(wiper), 32'h40);
    // page writes at both ends of general storage
    foreach (gp[i]) begin
      op(1'b1, gp[i], 4, 32'hA55A0FF0 ^ 32'(gp[i]));
      idle();
      op(1'b0, gp[i], 4, 32'h0);
      chk(q, 32'hA55A0FF0 ^ 32'(gp[i]));
    end
    op(1'b1, 11'h7FC, 1, 32'h0);
    chk(32'(nk), 32'h1);
    // top write with volatile bit clear, then a command while programming
    op(1'b1, 11'h7FF, 1, 32'h15);
    chk(32'(wiper), 32'h15);
    for (int i = 0; i < 100 && lnk.busy !== 1'b1; i++) @(posedge pclk);
    op(1'b0, 11'h7FF, 1, 32'h0);
    chk(32'(nk), 32'h1);
    idle();
    // control and top in one write
    op(1'b1, 11'h7FE, 2, 32'h2A80);
    chk(32'(vol), 32'h1);
    chk(32'(wiper), 32'h2A);
    chk(32'(lnk.busy), 32'h0);
    op(1'b0, 11'h7FF, 1, 32'h0);
    chk(32'(q[7:0]), 32'h2A);
    foreach (tv[i]) begin
      op(1'b1, 11'h7FF, 1, 32'(tv[i]));
      chk(32'(wiper), 32'(tv[i] & 8'h7F));
      op(1'b0, 11'h7FF, 1, 32'h0);
      chk(32'(q[7:0]), 32'(tv[i] & 8'h7F));
    end
    op(1'b1, 11'h7FE, 1, 32'h0);
    op(1'b0, 11'h7FF, 1, 32'h0);
    chk(32'(q[7:0]), 32'h15);
    apb(1'b0, 8'h20, 32'h0, q);
    chk(32'(e), 32'h1);
    // second reset reloads the stored value
    presetn <= 1'b0;
    @(posedge pclk);
    chk(32'(wiper), 32'h40);
    presetn <= 1'b1;
    idle();
    chk(32'(wiper), 32'h15);
    chk(32'(vol), 32'h0);
    end_sim();
  end
  // watchdog
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule : tb_wiper_register_and_nv_memory_map
